// file: hdl/adcr_regs.sv
// control register bank of a dual-core audio decoder, reached over a two-wire slave port
// assumes scl, sda and the strap are asynchronous pins; sda is open drain, resolved outside
// Behaviour
// R1 - general bit 0 holds the whole device in reset while one
// R2 - general bit 1 one disables the buffered clock output, zero drives it
// R3 - divider bits 3:2 give quarter, half, full clock; code 11 reserved
// R4 - bits 4 and 5 enable input and output interrupts of first core
// R5 - bits 6 and 7 enable input and output interrupts of second core
// R6 - bit 8 says audio master clock is 256 or 384 times sample rate
// R7 - bit 9 splits program memory 12/8 or 8/12 kbytes between cores
// R8 - host keeps serial input port mode bits 1:0 at 00
// R9 - serial bit 2 selects two-wire audio or japanese lsb-justified input
// R10 - serial bit 3 makes aux input a core flag or word-aligned channel
// R11 - every field reachable through the two-wire slave, up to 400 kHz
// R12 - strap high blocks host writes and forces stand-alone defaults; the code still lets the host write general bit 0
`timescale 1ns/1ps
module adcr_regs #(
	parameter logic [6:0] SLAVE_ADDR = adcr_pkg::SLAVE_ADDR_DEFAULT
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// two-wire slave pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// strap
	input wire logic host_free_strap,
	// device reset
	output logic device_soft_reset,
	// buffered clock
	output logic buffered_clock_out,
	output logic buffered_clock_oe,
	// core interrupt enables
	output logic first_core_input_irq_enable,
	output logic first_core_output_irq_enable,
	output logic second_core_input_irq_enable,
	output logic second_core_output_irq_enable,
	// clocking and memory
	output logic audio_clock_ratio_select,
	output logic program_memory_split,
	// serial input port
	output logic [1:0] input_port_mode,
	output logic input_format_select,
	output logic aux_input_function
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic scl_s, sda_s, strap_s;
	logic scl_d, sda_d;
	// idle levels: scl and sda high, strap low, so no false edge or force after reset
	adcr_sync #(.WIDTH(3), .RESET_VALUE(3'h6)) adcr_sync_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in({scl_in, sda_in, host_free_strap}),
		.pin_sync({scl_s, sda_s, strap_s})
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

	// ----------------------------------------
	// register storage and read decode
	// ----------------------------------------
	logic [adcr_pkg::GENERAL_WIDTH-1:0] general_control;
	logic [adcr_pkg::SERIAL_WIDTH-1:0] serial_port_control;

	function automatic logic [15:0] read_word(input logic [15:0] addr,
		input logic [adcr_pkg::GENERAL_WIDTH-1:0] gen, input logic [adcr_pkg::SERIAL_WIDTH-1:0] ser);
		read_word = 16'h0000;
		if (addr == adcr_pkg::GENERAL_CONTROL_ADDR)
			read_word = {6'h00, gen};
		else if (addr == adcr_pkg::SERIAL_PORT_CONTROL_ADDR)
			read_word = {12'h000, ser};
	endfunction : read_word

	// ----------------------------------------
	// two-wire slave
	// ----------------------------------------
	adcr_pkg::adcr_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift_in, shift_out, data_hi;
	logic [1:0] byte_idx;
	logic [15:0] sub_addr;
	logic read_mode, read_lo, master_nack, wr_strobe;
	logic [15:0] wr_data;
	logic [15:0] rd_word, rd_next;
	assign rd_word = read_word(sub_addr, general_control, serial_port_control);
	assign rd_next = read_word(sub_addr + 16'h0001, general_control, serial_port_control);

	always_ff @(posedge clk_sys or posedge rst) begin // [R11]
		if (rst) begin
			state <= adcr_pkg::ADCR_IDLE;
			bit_cnt <= 4'h0;
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			byte_idx <= 2'h0;
			sub_addr <= 16'h0000;
			data_hi <= 8'h00;
			read_mode <= 1'b0;
			read_lo <= 1'b0;
			master_nack <= 1'b0;
			sda_oe <= 1'b0;
			wr_strobe <= 1'b0;
			wr_data <= 16'h0000;
		end else begin
			wr_strobe <= 1'b0;
			// step only after the word has landed, so the write still sees its own address
			if (wr_strobe)
				sub_addr <= sub_addr + 16'h0001;
			if (bus_start) begin
				state <= adcr_pkg::ADCR_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state <= adcr_pkg::ADCR_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
				adcr_pkg::ADCR_ADDR, adcr_pkg::ADCR_WR_BYTE: begin
					shift_in <= {shift_in[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end
				adcr_pkg::ADCR_RD_BYTE: bit_cnt <= bit_cnt + 4'h1;
				adcr_pkg::ADCR_ACK_RD: master_nack <= sda_s;
				default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
				adcr_pkg::ADCR_ADDR: begin
					if (bit_cnt == adcr_pkg::BITS_PER_BYTE) begin
						if (shift_in[7:1] == SLAVE_ADDR) begin
							state <= adcr_pkg::ADCR_ACK_ADDR;
							read_mode <= shift_in[0];
							sda_oe <= 1'b1;
						end else begin
							state <= adcr_pkg::ADCR_IDLE;
						end
					end
				end
				adcr_pkg::ADCR_ACK_ADDR: begin
					bit_cnt <= 4'h0;
					if (read_mode) begin
						// a read starts on the high byte of the last set sub-address
						state <= adcr_pkg::ADCR_RD_BYTE;
						shift_out <= {rd_word[14:8], 1'b0};
						read_lo <= 1'b0;
						sda_oe <= ~rd_word[15];
					end else begin
						state <= adcr_pkg::ADCR_WR_BYTE;
						byte_idx <= 2'h0;
						sda_oe <= 1'b0;
					end
				end
				adcr_pkg::ADCR_WR_BYTE: begin
					if (bit_cnt == adcr_pkg::BITS_PER_BYTE) begin
						state <= adcr_pkg::ADCR_ACK_WR;
						sda_oe <= 1'b1;
						case (byte_idx)
						2'h0: sub_addr[15:8] <= shift_in;
						2'h1: sub_addr[7:0] <= shift_in;
						2'h2: data_hi <= shift_in;
						default: begin
							wr_strobe <= 1'b1;
							wr_data <= {data_hi, shift_in};
						end
						endcase
						byte_idx <= (byte_idx == 2'h3) ? 2'h2 : byte_idx + 2'h1;
					end
				end
				adcr_pkg::ADCR_ACK_WR: begin
					state <= adcr_pkg::ADCR_WR_BYTE;
					bit_cnt <= 4'h0;
					sda_oe <= 1'b0;
				end
				adcr_pkg::ADCR_RD_BYTE: begin
					if (bit_cnt == adcr_pkg::BITS_PER_BYTE) begin
						state <= adcr_pkg::ADCR_ACK_RD;
						sda_oe <= 1'b0;
					end else begin
						sda_oe <= ~shift_out[7];
						shift_out <= {shift_out[6:0], 1'b0};
					end
				end
				adcr_pkg::ADCR_ACK_RD: begin
					bit_cnt <= 4'h0;
					if (master_nack) begin
						state <= adcr_pkg::ADCR_IDLE;
						sda_oe <= 1'b0;
					end else if (!read_lo) begin
						state <= adcr_pkg::ADCR_RD_BYTE;
						read_lo <= 1'b1;
						shift_out <= {rd_word[6:0], 1'b0};
						sda_oe <= ~rd_word[7];
					end else begin
						// next word: address advances together with its fetch
						state <= adcr_pkg::ADCR_RD_BYTE;
						read_lo <= 1'b0;
						sub_addr <= sub_addr + 16'h0001;
						shift_out <= {rd_next[14:8], 1'b0};
						sda_oe <= ~rd_next[15];
					end
				end
				default: state <= adcr_pkg::ADCR_IDLE;
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge clk_sys)
		sda_out <= 1'b0;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	logic [adcr_pkg::GENERAL_WIDTH-1:0] gen_wr_mask;
	assign gen_wr_mask = strap_s ? adcr_pkg::GENERAL_STRAP_WRITABLE : '1;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			general_control <= adcr_pkg::GENERAL_RESET;
			serial_port_control <= adcr_pkg::SERIAL_RESET;
		end else begin
			if (strap_s) begin // [R12]
				general_control <= (general_control & adcr_pkg::GENERAL_STRAP_WRITABLE)
					| (adcr_pkg::GENERAL_HOST_FREE_STRAP & ~adcr_pkg::GENERAL_STRAP_WRITABLE);
				serial_port_control <= adcr_pkg::SERIAL_HOST_FREE_STRAP;
			end
			if (wr_strobe && sub_addr == adcr_pkg::GENERAL_CONTROL_ADDR) begin // [R12]
				general_control <= (wr_data[adcr_pkg::GENERAL_WIDTH-1:0] & gen_wr_mask)
					| ((strap_s ? adcr_pkg::GENERAL_HOST_FREE_STRAP : general_control) & ~gen_wr_mask);
			end
			// mode bits stored as written; only 00 is meaningful [R8]
			if (wr_strobe && sub_addr == adcr_pkg::SERIAL_PORT_CONTROL_ADDR && !strap_s)
				serial_port_control <= wr_data[adcr_pkg::SERIAL_WIDTH-1:0];
		end
	end

	// ----------------------------------------
	// field outputs
	// ----------------------------------------
	assign device_soft_reset = general_control[adcr_pkg::SOFT_RESET_BIT]; // [R1]
	assign first_core_input_irq_enable = general_control[adcr_pkg::FIRST_CORE_INPUT_IRQ_BIT]; // [R4]
	assign first_core_output_irq_enable = general_control[adcr_pkg::FIRST_CORE_OUTPUT_IRQ_BIT]; // [R4]
	assign second_core_input_irq_enable = general_control[adcr_pkg::SECOND_CORE_INPUT_IRQ_BIT]; // [R5]
	assign second_core_output_irq_enable = general_control[adcr_pkg::SECOND_CORE_OUTPUT_IRQ_BIT]; // [R5]
	assign audio_clock_ratio_select = general_control[adcr_pkg::AUDIO_CLOCK_RATIO_BIT]; // [R6]
	assign program_memory_split = general_control[adcr_pkg::PROGRAM_MEMORY_SPLIT_BIT]; // [R7]
	assign input_port_mode = serial_port_control[adcr_pkg::INPUT_PORT_MODE_LSB +: 2];
	assign input_format_select = serial_port_control[adcr_pkg::INPUT_FORMAT_SELECT_BIT]; // [R9]
	assign aux_input_function = serial_port_control[adcr_pkg::AUX_INPUT_FUNCTION_BIT]; // [R10]

	// ----------------------------------------
	// buffered clock output
	// ----------------------------------------
	logic [1:0] div_cnt;
	logic div_q;
	logic [1:0] div_code;
	logic clock_out_gate_n;
	assign div_code = general_control[adcr_pkg::CLOCK_OUT_DIVIDER_LSB +: 2];
	assign clock_out_gate_n = general_control[adcr_pkg::CLOCK_OUT_GATE_N_BIT];

	always_ff @(posedge clk_sys or posedge rst) begin // [R3]
		if (rst) begin
			div_cnt <= 2'h0;
			div_q <= 1'b0;
			buffered_clock_oe <= 1'b0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
			case (div_code)
			adcr_pkg::DIV_QUARTER: div_q <= div_cnt[1];
			adcr_pkg::DIV_HALF: div_q <= ~div_q;
			default: div_q <= 1'b0;
			endcase
			buffered_clock_oe <= ~clock_out_gate_n; // [R2]
		end
	end

	// full rate cannot come from a flop; passes the clock itself, gated by a register
	assign buffered_clock_out = (div_code == adcr_pkg::DIV_FULL) ? (clk_sys & buffered_clock_oe)
		: (div_q & buffered_clock_oe); // [R2] [R3]
endmodule : adcr_regs

// file: hdl/adcr_pkg.sv
// constants of the audio decoder control register bank
// shared by the register bank and the self-checking bench
package adcr_pkg;
	// ----------------------------------------
	// register addresses on the two-wire port
	// ----------------------------------------
	localparam logic [15:0] GENERAL_CONTROL_ADDR = 16'h8000;
	localparam logic [15:0] SERIAL_PORT_CONTROL_ADDR = 16'h8001;
	// ----------------------------------------
	// general control fields
	// ----------------------------------------
	localparam int SOFT_RESET_BIT = 0;
	localparam int CLOCK_OUT_GATE_N_BIT = 1;
	localparam int CLOCK_OUT_DIVIDER_LSB = 2;
	localparam int FIRST_CORE_INPUT_IRQ_BIT = 4;
	localparam int FIRST_CORE_OUTPUT_IRQ_BIT = 5;
	localparam int SECOND_CORE_INPUT_IRQ_BIT = 6;
	localparam int SECOND_CORE_OUTPUT_IRQ_BIT = 7;
	localparam int AUDIO_CLOCK_RATIO_BIT = 8;
	localparam int PROGRAM_MEMORY_SPLIT_BIT = 9;
	localparam int GENERAL_WIDTH = 10;
	// ----------------------------------------
	// serial port control fields
	// ----------------------------------------
	localparam int INPUT_PORT_MODE_LSB = 0;
	localparam int INPUT_FORMAT_SELECT_BIT = 2;
	localparam int AUX_INPUT_FUNCTION_BIT = 3;
	localparam int SERIAL_WIDTH = 4;
	// ----------------------------------------
	// reset and stand-alone values
	// ----------------------------------------
	localparam logic [GENERAL_WIDTH-1:0] GENERAL_RESET = 10'h000;
	localparam logic [SERIAL_WIDTH-1:0] SERIAL_RESET = 4'h0;
	localparam logic [GENERAL_WIDTH-1:0] GENERAL_HOST_FREE_STRAP = 10'h05a;
	localparam logic [SERIAL_WIDTH-1:0] SERIAL_HOST_FREE_STRAP = 4'h0;
	// bits the host may still write while the strap is high
	localparam logic [GENERAL_WIDTH-1:0] GENERAL_STRAP_WRITABLE = 10'h001;
	// ----------------------------------------
	// clock divider codes
	// ----------------------------------------
	localparam logic [1:0] DIV_QUARTER = 2'h0;
	localparam logic [1:0] DIV_HALF = 2'h1;
	localparam logic [1:0] DIV_FULL = 2'h2;
	// ----------------------------------------
	// two-wire slave
	// ----------------------------------------
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2a; // arbitrary value
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [2:0] {
		ADCR_IDLE,
		ADCR_ADDR,
		ADCR_ACK_ADDR,
		ADCR_WR_BYTE,
		ADCR_ACK_WR,
		ADCR_RD_BYTE,
		ADCR_ACK_RD
	} adcr_state_t;
endpackage : adcr_pkg

// file: hdl/adcr_sync.sv
// two flip-flop synchroniser for asynchronous pins
// assumes one clock domain, clk_sys, and asynchronous reset rst
`timescale 1ns/1ps
module adcr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage1 <= RESET_VALUE;
			pin_sync <= RESET_VALUE;
		end else begin
			stage1 <= pin_in;
			pin_sync <= stage1;
		end
	end
endmodule : adcr_sync

// file: testbench/adcr_regs_asserts.sv
// checker of the audio decoder control register bank
// bound to adcr_regs, sees only its ports
`timescale 1ns/1ps
module adcr_regs_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pins
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic host_free_strap,
	// register outputs
	input wire logic device_soft_reset,
	input wire logic buffered_clock_out,
	input wire logic buffered_clock_oe,
	input wire logic first_core_input_irq_enable,
	input wire logic first_core_output_irq_enable,
	input wire logic second_core_input_irq_enable,
	input wire logic second_core_output_irq_enable,
	input wire logic audio_clock_ratio_select,
	input wire logic program_memory_split,
	input wire logic [1:0] input_port_mode,
	input wire logic input_format_select,
	input wire logic aux_input_function
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [3:0] strap_quiet;
	// forced values lift a few cycles after the strap falls, so skip that spell
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strap_quiet <= 4'h0;
		end else if (host_free_strap) begin
			strap_quiet <= 4'h0;
		end else if (strap_quiet != 4'h8) begin
			strap_quiet <= strap_quiet + 4'h1;
		end
	end
	property p_soft_reset; $changed(device_soft_reset) |-> !scl_in && !$past(scl_in, 2); endproperty
	property p_gate_off; !buffered_clock_oe |-> !buffered_clock_out; endproperty
	property p_div_high; buffered_clock_out ##1 buffered_clock_out |=> !buffered_clock_out; endproperty
	property p_first_irq;
		$changed({first_core_input_irq_enable, first_core_output_irq_enable}) && strap_quiet == 4'h8
			|-> !scl_in && !$past(scl_in, 2);
	endproperty
	property p_second_irq;
		$changed({second_core_input_irq_enable, second_core_output_irq_enable}) && strap_quiet == 4'h8
			|-> !scl_in && !$past(scl_in, 2);
	endproperty
	property p_clock_mem;
		$changed({audio_clock_ratio_select, program_memory_split}) && strap_quiet == 4'h8 |-> !scl_in;
	endproperty
	property p_serial;
		$changed({input_format_select, aux_input_function}) && strap_quiet == 4'h8 |-> !$past(scl_in, 2);
	endproperty
	property p_ack; $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2); endproperty
	property p_strap;
		host_free_strap[*6] |-> !buffered_clock_oe && first_core_input_irq_enable && !first_core_output_irq_enable
			&& second_core_input_irq_enable && !second_core_output_irq_enable && !audio_clock_ratio_select
			&& !program_memory_split && input_port_mode == 2'h0 && !input_format_select && !aux_input_function;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset moved outside a bus write");
	a_gate_off: assert property (p_gate_off)
		else $error("clock out active while disabled");
	a_div_high: assert property (p_div_high)
		else $error("clock out high too long");
	a_first_irq: assert property (p_first_irq)
		else $error("first core enables moved outside a bus write");
	a_second_irq: assert property (p_second_irq)
		else $error("second core enables moved outside a bus write");
	a_clock_mem: assert property (p_clock_mem)
		else $error("ratio or split moved outside a bus write");
	a_serial: assert property (p_serial)
		else $error("serial fields moved outside a bus write");
	a_ack: assert property (p_ack)
		else $error("sda moved while scl high");
	a_strap: assert property (p_strap)
		else $error("stand-alone values not held");
	c_strap: cover property (host_free_strap[*6]);
	c_ack: cover property ($rose(sda_oe));
	c_soft_reset: cover property ($rose(device_soft_reset));
endmodule : adcr_regs_asserts

// file: testbench/adcr_host_model.sv
// two-wire bus host driving the register bank
// assumes an open-drain sda with pull-up, resolved by the bench
`timescale 1ns/1ps
module adcr_host_model (
	// clock
	input wire logic clk_sys,
	// bus
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	// 64 clocks a bit keeps the bus under 400 kHz
	localparam int QTR = 16;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic bit_io(input logic b, output logic seen);
		tick(QTR);
		sda <= b;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		seen = sda_line;
		tick(QTR);
		scl <= 1'b0;
	endtask : bit_io
	task automatic start_c();
		tick(QTR);
		sda <= 1'b1;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		sda <= 1'b0;
		tick(QTR);
		scl <= 1'b0;
	endtask : start_c
	task automatic stop_c();
		tick(QTR);
		sda <= 1'b0;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		sda <= 1'b1;
		tick(QTR);
	endtask : stop_c
	task automatic put_byte(input logic [7:0] b, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, nack);
	endtask : put_byte
	task automatic get_byte(output logic [7:0] b, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(last, s);
	endtask : get_byte
endmodule : adcr_host_model

// file: testbench/audio_decoder_control_regs_tb.sv
// self-checking bench of the audio decoder control register bank
// assumes adcr_regs, the host model and a pulled-up sda line
`timescale 1ns/1ps
module audio_decoder_control_regs_tb;
	localparam logic [15:0] GEN = adcr_pkg::GENERAL_CONTROL_ADDR;
	localparam logic [15:0] SER = adcr_pkg::SERIAL_PORT_CONTROL_ADDR;
	localparam logic [7:0] WADDR = {adcr_pkg::SLAVE_ADDR_DEFAULT, 1'b0};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic host_free_strap = 1'b0;
	logic scl, sda, sda_line, sda_out, sda_oe, device_soft_reset, buffered_clock_out, buffered_clock_oe;
	logic first_core_input_irq_enable, first_core_output_irq_enable, second_core_input_irq_enable;
	logic second_core_output_irq_enable, audio_clock_ratio_select, program_memory_split;
	logic input_format_select, aux_input_function;
	logic [1:0] input_port_mode;
	int fail_count = 0;
	int compares = 0;
	int rises = 0;
	always #20 clk_sys = ~clk_sys;
	always @(posedge buffered_clock_out) rises++;
	assign sda_line = sda & (sda_oe ? sda_out : 1'b1);
	adcr_regs adcr_regs_i (.clk_sys, .rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .host_free_strap,
		.device_soft_reset, .buffered_clock_out, .buffered_clock_oe, .first_core_input_irq_enable,
		.first_core_output_irq_enable, .second_core_input_irq_enable, .second_core_output_irq_enable,
		.audio_clock_ratio_select, .program_memory_split, .input_port_mode, .input_format_select, .aux_input_function);
	adcr_host_model adcr_host_model_i (.clk_sys, .sda_line, .scl, .sda);
	function automatic logic [15:0] gen_seen();
		return {6'h00, program_memory_split, audio_clock_ratio_select, second_core_output_irq_enable,
			second_core_input_irq_enable, first_core_output_irq_enable, first_core_input_irq_enable, 2'h0,
			~buffered_clock_oe, device_soft_reset};
	endfunction : gen_seen
	function automatic logic [15:0] ser_seen();
		return {12'h000, aux_input_function, input_format_select, input_port_mode};
	endfunction : ser_seen
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic close_out();
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic put(input logic [7:0] b);
		logic nack;
		adcr_host_model_i.put_byte(b, nack);
		chk({15'h0000, nack}, 16'h0000);
	endtask : put
	task automatic wr(input logic [15:0] a, input logic [15:0] d0, input logic [15:0] d1, input int n);
		adcr_host_model_i.start_c();
		put(WADDR);
		put(a[15:8]);
		put(a[7:0]);
		put(d0[15:8]);
		put(d0[7:0]);
		if (n > 1) begin
			put(d1[15:8]);
			put(d1[7:0]);
		end
		adcr_host_model_i.stop_c();
		repeat (8) @(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		adcr_host_model_i.start_c();
		put(WADDR);
		put(a[15:8]);
		put(a[7:0]);
		adcr_host_model_i.start_c();
		put(WADDR | 8'h01);
		adcr_host_model_i.get_byte(d[15:8], 1'b0);
		adcr_host_model_i.get_byte(d[7:0], 1'b1);
		adcr_host_model_i.stop_c();
	endtask : rd
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_fields();
		logic [15:0] gv [3] = '{16'h0151, 16'h02a2, 16'h0000};
		logic [15:0] sv [3] = '{16'h0004, 16'h0008, 16'h0000};
		chk(gen_seen(), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			wr(GEN, gv[i], 16'h0000, 1);
			chk(gen_seen(), gv[i] & 16'h03f3);
			wr(SER, sv[i], 16'h0000, 1); // mode bits stay 00
			chk(ser_seen(), sv[i]);
		end
	endtask : s_fields
	task automatic s_divider();
		logic [15:0] code [5] = '{16'h0000, 16'h0004, 16'h0008, 16'h000c, 16'h000a};
		logic [15:0] want [5] = '{16'h0008, 16'h0010, 16'h0020, 16'h0000, 16'h0000};
		for (int i = 0; i < 5; i++) begin
			wr(GEN, code[i], 16'h0000, 1);
			@(negedge clk_sys);
			rises = 0;
			repeat (32) @(negedge clk_sys);
			chk(16'(rises), want[i]);
		end
	endtask : s_divider
	task automatic s_pair_and_miss();
		logic [15:0] d;
		logic nack;
		wr(GEN, 16'h0150, 16'h000c, 2);
		chk(gen_seen(), 16'h0150);
		chk(ser_seen(), 16'h000c);
		rd(GEN, d);
		chk(d, 16'h0150);
		rd(SER, d);
		chk(d, 16'h000c);
		rd(16'h8005, d);
		chk(d, 16'h0000);
		adcr_host_model_i.start_c();
		adcr_host_model_i.put_byte(WADDR ^ 8'h02, nack);
		adcr_host_model_i.stop_c();
		chk({15'h0000, nack}, 16'h0001);
	endtask : s_pair_and_miss
	task automatic s_strap();
		logic [15:0] sa;
		sa = {6'h00, adcr_pkg::GENERAL_HOST_FREE_STRAP} & 16'h03f3;
		host_free_strap <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk(gen_seen(), sa);
		chk(ser_seen(), {12'h000, adcr_pkg::SERIAL_HOST_FREE_STRAP});
		wr(GEN, 16'h0301, 16'h0000, 1);
		chk(gen_seen(), sa | 16'h0001);
		host_free_strap <= 1'b0;
		wr(GEN, 16'h0000, 16'h0000, 1);
		chk(gen_seen(), 16'h0000);
	endtask : s_strap
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		s_fields();
		s_divider();
		s_pair_and_miss();
		s_strap();
		close_out();
	end
	initial begin
		repeat (99000) @(posedge clk_sys);
		fail_count++;
		$display("Error at %0t: run limit reached", $time);
		close_out();
	end
endmodule : audio_decoder_control_regs_tb
bind adcr_regs adcr_regs_asserts adcr_regs_asserts_i (.clk_sys, .rst, .scl_in, .sda_oe, .host_free_strap,
	.device_soft_reset, .buffered_clock_out, .buffered_clock_oe, .first_core_input_irq_enable,
	.first_core_output_irq_enable, .second_core_input_irq_enable, .second_core_output_irq_enable,
	.audio_clock_ratio_select, .program_memory_split, .input_port_mode, .input_format_select, .aux_input_function);
